// *** hw/rsc_buf2.v ***
`timescale 1ns/1ps
`default_nettype none

module rsc_buf2 #(
	parameter W = 9
) (
	// clock and reset
	input  wire         clk,
	input  wire         rst_b,
	input  wire         flush,
	// filling side
	input  wire         in_valid,
	output wire         in_ready,
	input  wire [W-1:0] in_data,
	// draining side
	output wire         out_valid,
	input  wire         out_ready,
	output wire [W-1:0] out_data
);

	reg [W-1:0] e0_q;
	reg [W-1:0] e1_q;
	reg [1:0]   cnt_q;
	wire        push;
	wire        pop;

	// full refuses a push even when a pop frees a slot; keeps ready off the pop path
	assign in_ready  = (cnt_q != 2'h2);
	assign out_valid = (cnt_q != 2'h0);
	assign out_data  = e0_q;
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;

	always @(posedge clk) begin
		if (!rst_b || flush) begin
			cnt_q <= 2'h0;
			e0_q  <= {W{1'b0}};
			e1_q  <= {W{1'b0}};
		end else begin
			case ({push, pop})
				2'b10: begin
					if (cnt_q == 2'h0)
						e0_q <= in_data;
					else
						e1_q <= in_data;
					cnt_q <= cnt_q + 2'h1;
				end
				2'b01: begin
					e0_q  <= e1_q;
					cnt_q <= cnt_q - 2'h1;
				end
				2'b11: begin
					if (cnt_q == 2'h1) begin
						e0_q <= in_data;
					end else begin
						e0_q <= e1_q;
						e1_q <= in_data;
					end
				end
				default: begin
					cnt_q <= cnt_q;
				end
			endcase
		end
	end

endmodule // rsc_buf2

`default_nettype wire

// *** hw/rsc_port.v ***
// Contract
// - a synchronous transaction lasts exactly while transfer-enable is high.
// - host holds data stable over serial-clock rise; device samples there.
// - device changes its output bit after the serial-clock falling edge.
// - during reads the data pin is released while the serial clock is high.
// - transfer-enable low abandons the transaction, idles, tri-states data.
// - command byte then parameters; one data byte per write command.
// - page read runs from the address to the end of its 32-byte page.
// - asynchronous page read cannot be aborted before the page boundary.
// - asynchronous page read ends with a 16-bit crc; synchronous has none.
// - crc x16+x15+x2+1, cleared per read, fed every sent page byte.
// - crc goes out from bit 15 down to bit 0.
// - missing stop bit discards the partial transaction, parser idle.
// - over 10 bit times between received bytes returns parser to idle.
// - unknown command byte is ignored with no response.
// - codes: 22h write, 33h read, 44h test, 55h measure, A5h clear.
// - write is command, address byte with top bit 0, data byte.
// - read is command, high address, low address, then data at once.
// - asynchronous transmit line released after last byte and crc.
// - synchronous clocking past page end wraps to the page start.
// - measure starts enabled conversions only while logging is inactive.
// - clear memory acts only while clear_permit is set.
// - link_select high chooses synchronous link, low the asynchronous one.
// - bytes travel least-significant bit first on both links.
// - asynchronous link: half duplex, 9600 bit/s, start, 8 data, stop.
`timescale 1ns/1ps
`default_nettype none
`include "rsc_map.vh"

module rsc_port #(
	parameter CW      = 18,
	parameter BIT_CYC = `RSC_CLK_HZ / `RSC_BAUD,
	parameter GAP_CYC = `RSC_GAP_BITS * BIT_CYC
) (
	// clock and reset
	input  wire        ref_clk,
	input  wire        rst_b,
	// link choice
	input  wire        link_select,
	// synchronous link
	input  wire        xfer_en,
	input  wire        sclk,
	input  wire        sio_in,
	output reg         sio_out,
	output reg         sio_oe,
	// asynchronous link
	input  wire        rxd,
	output reg         txd,
	output reg         txd_oe,
	// configuration from the register bank
	input  wire        temp_channel_enable,
	input  wire [2:0]  adc_channel_enable,
	input  wire        logging_active,
	input  wire        clear_permit,
	// register write
	output reg         reg_wr,
	output reg  [6:0]  reg_wr_addr,
	output reg  [7:0]  reg_wr_data,
	// memory read
	output reg         mem_rd_req,
	output reg  [15:0] mem_rd_addr,
	input  wire        mem_rd_valid,
	input  wire [7:0]  mem_rd_data,
	// command strobes
	output reg         meas_start,
	output reg         meas_temp,
	output reg  [2:0]  meas_adc,
	output reg         spec_test,
	output reg         clear_start
);

	localparam [3:0] P_CMD = 4'h0;
	localparam [3:0] P_WA  = 4'h1;
	localparam [3:0] P_WD  = 4'h2;
	localparam [3:0] P_RH  = 4'h3;
	localparam [3:0] P_RL  = 4'h4;
	localparam [3:0] P_RD  = 4'h5;
	localparam [3:0] P_CH  = 4'h6;
	localparam [3:0] P_CL  = 4'h7;
	localparam [3:0] P_END = 4'h8;

	localparam integer  BIT_I   = BIT_CYC - 1;
	localparam integer  HALF_I  = BIT_CYC / 2 - 1;
	localparam integer  GAP_I   = GAP_CYC - 1;
	localparam [CW-1:0] BIT_M1  = BIT_I[CW-1:0];
	localparam [CW-1:0] HALF_M1 = HALF_I[CW-1:0];
	localparam [CW-1:0] GAP_M1  = GAP_I[CW-1:0];

	function [7:0] rev8;
		input [7:0] b;
		integer i;
		begin
			for (i = 0; i < 8; i = i + 1)
				rev8[i] = b[7-i];
		end
	endfunction

	function [15:0] crc_byte;
		input [15:0] c;
		input [7:0]  d;
		integer i;
		reg fb;
		begin
			crc_byte = c;
			for (i = 0; i < 8; i = i + 1) begin
				fb = crc_byte[15] ^ d[i];
				crc_byte = {crc_byte[14:0], 1'b0} ^ (fb ? `RSC_CRC_POLY : 16'h0000);
			end
		end
	endfunction

	// pin synchronisers: select, enable, clock, data, receive
	reg  [4:0]    s1_q;
	reg  [4:0]    s2_q;
	reg           ck_prev_q;
	reg           rx_prev_q;
	reg           sel_prev_q;
	wire          sync_mode = s2_q[4];
	wire          en        = s2_q[3];
	wire          ck        = s2_q[2];
	wire          din       = s2_q[1];
	wire          rxl       = s2_q[0];
	wire          ck_rise   = ck & ~ck_prev_q;
	wire          ck_fall   = ~ck & ck_prev_q;

	// parser and fetch state
	reg  [3:0]    st_q;
	reg  [15:0]   fa_q;
	reg           pend_q;
	reg           drop_q;
	reg           fdone_q;
	reg           last_q;
	reg  [15:0]   crc_q;
	reg  [CW-1:0] gap_q;

	// receivers
	reg  [7:0]    ss_sh_q;
	reg  [2:0]    ss_cnt_q;
	reg           ss_v_q;
	reg           ur_busy_q;
	reg  [CW-1:0] ur_cyc_q;
	reg  [3:0]    ur_bit_q;
	reg  [7:0]    ur_sh_q;
	reg           ur_v_q;
	reg           ur_ferr_q;

	// transmitters
	reg  [2:0]    st_bit_q;
	reg  [6:0]    st_sh_q;
	reg           tx_busy_q;
	reg  [CW-1:0] tx_cyc_q;
	reg  [3:0]    tx_bit_q;
	reg  [8:0]    tx_sh_q;

	wire          byte_v = ss_v_q | ur_v_q;
	wire [7:0]    byte_d = sync_mode ? ss_sh_q : ur_sh_q;
	wire          in_req = (st_q != P_CMD) && (st_q < P_RD);
	wire          timeout = !sync_mode && in_req && (gap_q == GAP_M1);
	wire          link_clr = (sync_mode && !en) || (sync_mode != sel_prev_q);
	// async errors only matter before the read response starts
	wire          clr = link_clr || (in_req && (ur_ferr_q || timeout));

	wire          b_in_ready;
	wire          b_out_valid;
	wire [8:0]    b_out_data;
	reg           pop_ok;
	reg           tx_load;
	reg  [9:0]    tx_frame;
	wire          st_edge = sync_mode && en && ck_fall && (st_q == P_RD);

	rsc_buf2 #(
		.W(9)
	) u_buf (
		.clk       (ref_clk),
		.rst_b     (rst_b),
		.flush     (clr),
		.in_valid  (mem_rd_valid & pend_q & ~drop_q),
		.in_ready  (b_in_ready),
		.in_data   ({last_q, mem_rd_data}),
		.out_valid (b_out_valid),
		.out_ready (pop_ok),
		.out_data  (b_out_data)
	);

	always @(posedge ref_clk) begin
		if (!rst_b) begin
			// receive pin idles high; a low reset value would fake a start edge
			s1_q       <= 5'h01;
			s2_q       <= 5'h01;
			ck_prev_q  <= 1'b0;
			rx_prev_q  <= 1'b1;
			sel_prev_q <= 1'b0;
		end else begin
			s1_q       <= {link_select, xfer_en, sclk, sio_in, rxd};
			s2_q       <= s1_q;
			ck_prev_q  <= ck;
			rx_prev_q  <= rxl;
			sel_prev_q <= sync_mode;
		end
	end

	// synchronous receiver: sample on the rising serial-clock edge, lsb first
	always @(posedge ref_clk) begin
		ss_v_q <= 1'b0;
		if (!rst_b || !sync_mode || !en) begin
			ss_sh_q  <= 8'h00;
			ss_cnt_q <= 3'h0;
		end else if (ck_rise && st_q < P_RD) begin
			ss_sh_q  <= {din, ss_sh_q[7:1]};
			ss_cnt_q <= ss_cnt_q + 3'h1;
			ss_v_q   <= (ss_cnt_q == 3'h7);
		end
	end

	// asynchronous receiver: start edge, mid-bit sampling, stop check
	always @(posedge ref_clk) begin
		ur_v_q    <= 1'b0;
		ur_ferr_q <= 1'b0;
		if (!rst_b || sync_mode) begin
			ur_busy_q <= 1'b0;
			ur_cyc_q  <= {CW{1'b0}};
			ur_bit_q  <= 4'h0;
			ur_sh_q   <= 8'h00;
		end else if (!ur_busy_q) begin
			if (!rxl && rx_prev_q) begin
				ur_busy_q <= 1'b1;
				ur_cyc_q  <= HALF_M1;
				ur_bit_q  <= 4'h0;
			end
		end else if (ur_cyc_q != {CW{1'b0}}) begin
			ur_cyc_q <= ur_cyc_q - 1'b1;
		end else begin
			ur_cyc_q <= BIT_M1;
			ur_bit_q <= ur_bit_q + 4'h1;
			if (ur_bit_q == 4'h0) begin
				if (rxl)
					ur_busy_q <= 1'b0;
			end else if (ur_bit_q <= `RSC_CHR_LAST) begin
				ur_sh_q <= {rxl, ur_sh_q[7:1]};
			end else begin
				ur_busy_q <= 1'b0;
				ur_v_q    <= rxl;
				ur_ferr_q <= ~rxl;
			end
		end
	end

	// gap between received bytes of one transaction
	always @(posedge ref_clk) begin
		if (!rst_b || !in_req || ur_busy_q || byte_v || sync_mode)
			gap_q <= {CW{1'b0}};
		else if (gap_q != GAP_M1)
			gap_q <= gap_q + 1'b1;
	end

	// who drains the buffer and what the async transmitter loads next
	always @* begin
		pop_ok   = 1'b0;
		tx_load  = 1'b0;
		tx_frame = 10'h3FF;
		if (st_edge && st_bit_q == 3'h0) begin
			pop_ok = b_out_valid;
		end else if (!sync_mode && !tx_busy_q) begin
			case (st_q)
				P_RD: begin
					pop_ok   = b_out_valid;
					tx_load  = b_out_valid;
					tx_frame = {1'b1, b_out_data[7:0], 1'b0};
				end
				P_CH: begin
					tx_load  = 1'b1;
					tx_frame = {1'b1, rev8(crc_q[15:8]), 1'b0};
				end
				P_CL: begin
					tx_load  = 1'b1;
					tx_frame = {1'b1, rev8(crc_q[7:0]), 1'b0};
				end
				default: begin
					tx_load = 1'b0;
				end
			endcase
		end
	end

	// command parser and page fetch
	always @(posedge ref_clk) begin
		reg_wr      <= 1'b0;
		mem_rd_req  <= 1'b0;
		meas_start  <= 1'b0;
		spec_test   <= 1'b0;
		clear_start <= 1'b0;
		if (!rst_b) begin
			st_q        <= P_CMD;
			fa_q        <= 16'h0000;
			pend_q      <= 1'b0;
			drop_q      <= 1'b0;
			fdone_q     <= 1'b0;
			last_q      <= 1'b0;
			crc_q       <= `RSC_CRC_INIT;
			reg_wr_addr <= 7'h00;
			reg_wr_data <= 8'h00;
			mem_rd_addr <= 16'h0000;
			meas_temp   <= 1'b0;
			meas_adc    <= 3'h0;
			txd_oe      <= 1'b0;
		end else begin
			if (mem_rd_valid) begin
				pend_q <= 1'b0;
				drop_q <= 1'b0;
			end else if (clr && pend_q) begin
				drop_q <= 1'b1;
			end
			if (tx_load)
				txd_oe <= 1'b1;
			if (clr) begin
				st_q   <= P_CMD;
				// a mode switch mid-response must not leave the transmit line claimed
				txd_oe <= 1'b0;
			end else begin
				case (st_q)
					P_CMD: if (byte_v) begin
						case (byte_d)
							`RSC_CMD_WRITE: st_q <= P_WA;
							`RSC_CMD_READ:  st_q <= P_RH;
							`RSC_CMD_SPEC:  spec_test <= 1'b1;
							`RSC_CMD_MEAS: if (!logging_active) begin
								meas_start <= 1'b1;
								meas_temp  <= temp_channel_enable;
								meas_adc   <= adc_channel_enable;
							end
							`RSC_CMD_CLEAR: clear_start <= clear_permit;
							default: st_q <= P_CMD;
						endcase
					end
					P_WA: if (byte_v) begin
						reg_wr_addr <= byte_d[6:0];
						st_q <= byte_d[`RSC_WADDR_TOP] ? P_CMD : P_WD;
					end
					P_WD: if (byte_v) begin
						reg_wr_data <= byte_d;
						reg_wr      <= 1'b1;
						st_q        <= P_CMD;
					end
					P_RH: if (byte_v) begin
						fa_q[15:8] <= byte_d;
						st_q       <= P_RL;
					end
					P_RL: if (byte_v) begin
						fa_q[7:0] <= byte_d;
						fdone_q   <= 1'b0;
						crc_q     <= `RSC_CRC_INIT;
						st_q      <= P_RD;
					end
					P_RD: begin
						if (!pend_q && !fdone_q && b_in_ready && !mem_rd_valid) begin
							mem_rd_req  <= 1'b1;
							mem_rd_addr <= fa_q;
							pend_q      <= 1'b1;
							// the offset wraps inside the page
							fa_q[`RSC_PAGE_MSB:0] <= fa_q[`RSC_PAGE_MSB:0] + 5'h01;
							last_q  <= !sync_mode && (fa_q[`RSC_PAGE_MSB:0] == `RSC_PAGE_LAST);
							fdone_q <= !sync_mode && (fa_q[`RSC_PAGE_MSB:0] == `RSC_PAGE_LAST);
						end
						if (tx_load) begin
							crc_q <= crc_byte(crc_q, b_out_data[7:0]);
							if (b_out_data[8])
								st_q <= P_CH;
						end
					end
					P_CH: if (tx_load) st_q <= P_CL;
					P_CL: if (tx_load) st_q <= P_END;
					P_END: if (!tx_busy_q) begin
						txd_oe <= 1'b0;
						st_q   <= P_CMD;
					end
					default: st_q <= P_CMD;
				endcase
			end
		end
	end

	// synchronous transmitter: change data after the falling edge, release while high
	always @(posedge ref_clk) begin
		if (!rst_b || !sync_mode || !en || st_q != P_RD) begin
			sio_oe   <= 1'b0;
			sio_out  <= 1'b1;
			st_bit_q <= 3'h0;
			st_sh_q  <= 7'h7F;
		end else if (ck_rise) begin
			sio_oe <= 1'b0;
		end else if (st_edge) begin
			sio_oe   <= 1'b1;
			st_bit_q <= st_bit_q + 3'h1;
			if (st_bit_q == 3'h0) begin
				sio_out <= b_out_valid ? b_out_data[0] : 1'b1;
				st_sh_q <= b_out_valid ? b_out_data[7:1] : 7'h7F;
			end else begin
				sio_out <= st_sh_q[0];
				st_sh_q <= {1'b1, st_sh_q[6:1]};
			end
		end
	end

	// asynchronous transmitter: start, eight data bits lsb first, stop
	always @(posedge ref_clk) begin
		if (!rst_b || sync_mode) begin
			tx_busy_q <= 1'b0;
			tx_cyc_q  <= {CW{1'b0}};
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 9'h1FF;
			txd       <= 1'b1;
		end else if (tx_load) begin
			tx_busy_q <= 1'b1;
			txd       <= tx_frame[0];
			tx_sh_q   <= tx_frame[9:1];
			tx_bit_q  <= 4'h0;
			tx_cyc_q  <= BIT_M1;
		end else if (tx_busy_q) begin
			if (tx_cyc_q != {CW{1'b0}}) begin
				tx_cyc_q <= tx_cyc_q - 1'b1;
			end else if (tx_bit_q == `RSC_CHR_STOP) begin
				tx_busy_q <= 1'b0;
			end else begin
				txd      <= tx_sh_q[0];
				tx_sh_q  <= {1'b1, tx_sh_q[8:1]};
				tx_bit_q <= tx_bit_q + 4'h1;
				tx_cyc_q <= BIT_M1;
			end
		end
	end

endmodule // rsc_port

`default_nettype wire

// *** pkg/rsc_map.vh ***
`ifndef RSC_MAP_VH
`define RSC_MAP_VH

// device clock and asynchronous link timing
`define RSC_CLK_HZ      100000000
`define RSC_BAUD        9600
`define RSC_GAP_BITS    10

// command codes
`define RSC_CMD_WRITE   8'h22
`define RSC_CMD_READ    8'h33
`define RSC_CMD_SPEC    8'h44
`define RSC_CMD_MEAS    8'h55
`define RSC_CMD_CLEAR   8'hA5

// write address byte: top bit must be zero
`define RSC_WADDR_TOP   7
// byte offset within a 32-byte page
`define RSC_PAGE_MSB    4
`define RSC_PAGE_LAST   5'h1F

// character: bit index of the last data bit and of the stop bit
`define RSC_CHR_LAST    4'h8
`define RSC_CHR_STOP    4'h9

// crc x16+x15+x2+1
`define RSC_CRC_POLY    16'h8005
`define RSC_CRC_INIT    16'h0000

`endif

// *** sim/rsc_host.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_host #(
	parameter BIT = 16
) (
	// clock
	input wire logic ref_clk,
	// line pair
	input wire logic txd,
	output var logic rxd
);
	initial rxd = 1'b1;

	// a good stop returns at mid-bit so a reply start is not missed
	task automatic send(input logic [7:0] b, input logic stp);
		integer i;
		repeat (8) @(posedge ref_clk);
		rxd <= #1 1'b0;
		repeat (BIT) @(posedge ref_clk);
		for (i = 0; i < 8; i++) begin
			rxd <= #1 b[i];
			repeat (BIT) @(posedge ref_clk);
		end
		rxd <= #1 stp;
		repeat (stp ? BIT / 2 : BIT) @(posedge ref_clk);
		rxd <= #1 1'b1;
	endtask

	task automatic recv(output logic [7:0] b);
		integer i;
		integer n;
		n = 0;
		while (txd !== 1'b0 && n < 400) begin
			@(posedge ref_clk);
			n++;
		end
		repeat (BIT / 2) @(posedge ref_clk);
		for (i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge ref_clk);
			b[i] = txd;
		end
		repeat (BIT) @(posedge ref_clk);
	endtask
endmodule // rsc_host

`default_nettype wire

// *** sim/rsc_port_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_port_monitor (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_b,
	// link pins
	input wire logic link_select,
	input wire logic xfer_en,
	input wire logic sclk,
	input wire logic sio_oe,
	input wire logic txd,
	input wire logic txd_oe,
	// configuration
	input wire logic temp_channel_enable,
	input wire logic logging_active,
	input wire logic clear_permit,
	// strobes
	input wire logic reg_wr,
	input wire logic mem_rd_req,
	input wire logic meas_start,
	input wire logic meas_temp,
	input wire logic spec_test,
	input wire logic clear_start
);
	default clocking mon_cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_b);

	// pin inputs pass two flops plus an edge detect, hence the short windows
	AST_RD_RELEASE:
		assert property ($rose(sclk) |-> ##[1:5] !sio_oe) else $error("data pin held while sclk high");
	AST_ABORT:
		assert property ($fell(xfer_en) |-> ##[1:5] !sio_oe) else $error("data pin held after abort");
	AST_IDLE_LOW:
		assert property (!xfer_en [*6] |-> !sio_oe) else $error("data pin driven while idle");
	AST_ASYNC_QUIET:
		assert property (!link_select [*5] |-> !sio_oe) else $error("data pin driven in async mode");
	AST_SYNC_QUIET:
		assert property (link_select [*5] |-> !txd_oe) else $error("transmit active in sync mode");
	AST_TX_IDLE:
		assert property (!txd_oe |-> txd) else $error("transmit line low while released");
	AST_MEAS_GATE:
		assert property (meas_start |-> !$past(logging_active)
			&& meas_temp == $past(temp_channel_enable)) else $error("measure strobe wrong");
	AST_CLR_GATE:
		assert property (clear_start |-> $past(clear_permit)) else $error("clear without permit");
	AST_WR_PULSE:
		assert property (reg_wr |=> !reg_wr) else $error("write strobe longer than one cycle");
	AST_REQ_SPACE:
		assert property (mem_rd_req |=> !mem_rd_req [*3]) else $error("second fetch outstanding");
	AST_CMD_ONE:
		assert property ($onehot0({reg_wr, meas_start, spec_test, clear_start}))
			else $error("two command strobes at once");
endmodule // rsc_port_monitor

bind rsc_port rsc_port_monitor u_mon (
	.ref_clk, .rst_b, .link_select, .xfer_en, .sclk, .sio_oe, .txd, .txd_oe,
	.temp_channel_enable, .logging_active, .clear_permit, .reg_wr, .mem_rd_req,
	.meas_start, .meas_temp, .spec_test, .clear_start
);

`default_nettype wire

// *** sim/rsc_port_tb.sv ***
`timescale 1ns/1ps
`default_nettype none

module rsc_port_tb;
	logic        ref_clk = 0;
	logic        rst_b = 0;
	logic        link_select = 0;
	logic        xfer_en = 0;
	logic        sclk = 0;
	logic        sio_h = 1;
	logic        temp_channel_enable = 1;
	logic [2:0]  adc_channel_enable = 3'h5;
	logic        logging_active = 0;
	logic        clear_permit = 0;
	logic [2:0]  mv = 0;
	logic [7:0]  mem_rd_data = 0;
	logic [7:0]  b;
	logic [7:0]  a;
	logic [15:0] crc;
	integer      err_total = 0;
	integer      comparisons = 0;
	integer      cyc = 0;
	integer      n_wr = 0;
	integer      n_ms = 0;
	integer      n_sp = 0;
	integer      n_cl = 0;
	wire         sio_out, sio_oe, txd, txd_oe, rxd, reg_wr, mem_rd_req;
	wire         meas_start, meas_temp, spec_test, clear_start;
	wire [6:0]   reg_wr_addr;
	wire [7:0]   reg_wr_data;
	wire [15:0]  mem_rd_addr;
	wire [2:0]   meas_adc;
	wire         mem_rd_valid = mv[2];
	// a released pin shows the host's own level, flipped per read bit
	wire         sio_in = sio_oe ? sio_out : sio_h;

	rsc_port #(.BIT_CYC(16), .GAP_CYC(160)) uut (
		.ref_clk, .rst_b, .link_select, .xfer_en, .sclk, .sio_in, .sio_out, .sio_oe,
		.rxd, .txd, .txd_oe, .temp_channel_enable, .adc_channel_enable,
		.logging_active, .clear_permit, .reg_wr, .reg_wr_addr, .reg_wr_data,
		.mem_rd_req, .mem_rd_addr, .mem_rd_valid, .mem_rd_data, .meas_start,
		.meas_temp, .meas_adc, .spec_test, .clear_start
	);

	rsc_host h (.ref_clk, .txd, .rxd);

	always #5 ref_clk = ~ref_clk;

	// memory answers three cycles after each request
	always @(posedge ref_clk) begin
		mv <= #1 {mv[1:0], mem_rd_req};
		if (mem_rd_req)
			mem_rd_data <= #1 mem_rd_addr[7:0] ^ 8'h5A;
		if (rst_b) begin
			n_wr <= n_wr + reg_wr;
			n_ms <= n_ms + meas_start;
			n_sp <= n_sp + spec_test;
			n_cl <= n_cl + clear_start;
		end
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			err_total++;
			end_sim;
		end
	end

	task automatic wt(input integer n);
		repeat (n) @(posedge ref_clk);
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
		integer i;
		for (i = 0; i < 8; i++)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 16'h8005 : 16'h0000);
		return c;
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] x);
		integer i;
		for (i = 0; i < 8; i++)
			rev8[i] = x[7 - i];
	endfunction

	task automatic sbyte(input logic [7:0] v);
		integer i;
		for (i = 0; i < 8; i++) begin
			#1 sclk = 0;
			sio_h = v[i];
			wt(30);
			#1 sclk = 1;
			wt(30);
		end
	endtask

	task automatic rbyte(output logic [7:0] v);
		integer i;
		for (i = 0; i < 8; i++) begin
			#1 sclk = 0;
			sio_h = ~sio_h;
			wt(28);
			#2 v[i] = (sio_oe === 1'b1) ? sio_out : 1'bx;
			wt(2);
			#1 sclk = 1;
			wt(30);
		end
	endtask

	task end_sim;
		$display("err_total=%0d comparisons=%0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		wt(16);
		#1 rst_b = 1;
		wt(4);
		h.send(8'h22, 1); h.send(8'h05, 1); h.send(8'h5A, 1); wt(20);
		chk(n_wr, 1);
		chk({reg_wr_addr, reg_wr_data}, 32'h055A);
		// the bad stop must drop the pending write, else 22h lands as the address
		h.send(8'h22, 1); h.send(8'h01, 0); h.send(8'h22, 1); h.send(8'h06, 1);
		h.send(8'h33, 1); wt(20);
		chk({reg_wr_addr, reg_wr_data}, 32'h0633);
		h.send(8'h22, 1); h.send(8'h85, 1); h.send(8'h11, 1);
		h.send(8'h22, 1); wt(200); h.send(8'h07, 1); h.send(8'h44, 1); wt(20);
		chk(n_wr, 2);
		chk(n_sp, 1);
		h.send(8'h55, 1); wt(20);
		chk(n_ms, 1);
		chk({meas_temp, meas_adc}, 32'hD);
		#1 logging_active = 1;
		h.send(8'h55, 1); wt(20);
		chk(n_ms, 1);
		h.send(8'hA5, 1); wt(20);
		chk(n_cl, 0);
		#1 clear_permit = 1;
		h.send(8'hA5, 1); wt(20);
		chk(n_cl, 1);
		h.send(8'h33, 1); h.send(8'h00, 1); h.send(8'h1E, 1);
		crc = 16'h0000;
		a = 8'h1E;
		repeat (2) begin
			h.recv(b);
			chk(b, a ^ 8'h5A);
			crc = crc_upd(crc, a ^ 8'h5A);
			a = a + 8'h01;
		end
		h.recv(b);
		chk(b, rev8(crc[15:8]));
		h.recv(b);
		chk(b, rev8(crc[7:0]));
		wt(16);
		chk(txd_oe, 0);
		// a second read must start its crc from zero again
		h.send(8'h33, 1); h.send(8'h00, 1); h.send(8'h1F, 1);
		h.recv(b);
		chk(b, 8'h45);
		crc = crc_upd(16'h0000, 8'h45);
		h.recv(b);
		chk(txd_oe, 1);
		chk(b, rev8(crc[15:8]));
		h.recv(b);
		chk(b, rev8(crc[7:0]));
		wt(16);
		chk(txd_oe, 0);
		#1 link_select = 1;
		wt(10);
		#1 xfer_en = 1;
		wt(10);
		sbyte(8'h33); sbyte(8'h00); sbyte(8'h1F);
		rbyte(b);
		chk(b, 8'h45);
		rbyte(b);
		chk(b, 8'h5A);
		#1 sclk = 0;
		wt(10);
		chk(sio_oe, 1);
		#1 xfer_en = 0;
		wt(10);
		chk(sio_oe, 0);
		#1 xfer_en = 1;
		wt(10);
		sbyte(8'h22); sbyte(8'h09); sbyte(8'hC3);
		wt(10);
		#1 xfer_en = 0;
		wt(10);
		chk({reg_wr_addr, reg_wr_data}, 32'h09C3);
		chk(n_wr, 3);
		end_sim;
	end
endmodule // rsc_port_tb

`default_nettype wire
